// >>> verilog/scirx_status_baud.v
// Receive status flags, data buffer and baud generator with AHB-Lite slave
`include "scirx_map.vh"
`timescale 1ns/1ps
`default_nettype none

module scirx_status_baud (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [7:0]  haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// Serial line
	input  wire        rxdPin,
	// Transmit side
	output reg  [7:0]  txData,
	output reg         txLoad,
	output reg         baudTick,
	// Interrupt requests
	output wire        rxIrq,
	output wire        errIrq
);

	localparam ST_IDLE  = 2'd0;
	localparam ST_START = 2'd1;
	localparam ST_DATA  = 2'd2;
	localparam ST_STOP  = 2'd3;

	localparam integer QUIET_N  = `SCIRX_QUIET_BITS * `SCIRX_RT_PER_BIT;
	localparam [7:0]   QUIET_RT = QUIET_N[7:0];

	function [3:0] presDiv;
		input [1:0] sel;
		begin
			case (sel)
				2'd0:    presDiv = 4'd1;
				2'd1:    presDiv = 4'd3;
				2'd2:    presDiv = 4'd4;
				default: presDiv = 4'd13;
			endcase
		end
	endfunction

	function hit;
		input [7:0] a;
		input [7:0] ofs;
		begin
			hit = (a[7:2] == ofs[7:2]);
		end
	endfunction

	function maj3;
		input [2:0] s;
		begin
			maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
		end
	endfunction

	// Line synchroniser
	reg syncA_q;
	reg rxLine_q;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			syncA_q  <= 1'b1;
			rxLine_q <= 1'b1;
		end else begin
			syncA_q  <= rxdPin;
			rxLine_q <= syncA_q;
		end
	end

	// Software registers
	reg [7:0] baud_q;
	reg [7:0] ctl2_q;
	reg [3:0] ctl3_q;

	wire rxEn   = ctl2_q[`SCIRX_C2_RXEN];
	wire nine   = ctl2_q[`SCIRX_C2_NINE];
	wire parEn  = ctl2_q[`SCIRX_C2_PAREN];
	wire parOdd = ctl2_q[`SCIRX_C2_PARODD];

	// Baud chain
	reg [3:0] presCnt_q;
	reg [6:0] rateCnt_q;
	reg [1:0] quarter_q;
	reg [3:0] txPhase_q;

	wire       presTick = (presCnt_q == presDiv(baud_q[5:4]) - 4'd1);
	wire [6:0] rateTop  = (7'd1 << baud_q[2:0]) - 7'd1;
	wire       rateTick = presTick && (rateCnt_q == rateTop);
	wire       rtTick   = rateTick && (quarter_q == 2'd3);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			presCnt_q <= 4'd0;
			rateCnt_q <= 7'd0;
			quarter_q <= 2'd0;
			txPhase_q <= 4'd0;
			baudTick  <= 1'b0;
		end else begin
			presCnt_q <= presTick ? 4'd0 : presCnt_q + 4'd1;
			if (presTick) begin
				rateCnt_q <= rateTick ? 7'd0 : rateCnt_q + 7'd1;
			end
			if (rateTick) begin
				quarter_q <= quarter_q + 2'd1;
			end
			if (rtTick) begin
				txPhase_q <= txPhase_q + 4'd1;
			end
			baudTick <= rtTick && (txPhase_q == 4'd15);
		end
	end

	// Receiver
	reg [1:0] rxState_q;
	reg [3:0] rtCnt_q;
	reg [3:0] bitCnt_q;
	reg [1:0] smp_q;
	reg [8:0] shift_q;
	reg       noiseAcc_q;
	reg       progress_q;
	reg [7:0] quietCnt_q;
	reg       charDone_q;

	wire [2:0] samples = {rxLine_q, smp_q};
	wire       bitVal  = maj3(samples);
	wire       noisy   = (samples != 3'b000) && (samples != 3'b111);
	wire       midBit  = rtTick && (rtCnt_q == 4'd9);
	wire [3:0] bitsNeed = nine ? 4'd9 : 4'd8;
	wire       quietDet = rtTick && (quietCnt_q == QUIET_RT - 8'd1);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			rxState_q  <= ST_IDLE;
			rtCnt_q    <= 4'd0;
			bitCnt_q   <= 4'd0;
			smp_q      <= 2'b11;
			shift_q    <= 9'h000;
			noiseAcc_q <= 1'b0;
			progress_q <= 1'b0;
			quietCnt_q <= 8'd0;
			charDone_q <= 1'b0;
		end else begin
			charDone_q <= 1'b0;
			if (!rxEn) begin
				rxState_q  <= ST_IDLE;
				progress_q <= 1'b0;
				quietCnt_q <= 8'd0;
			end else if (rtTick) begin
				if (rxState_q != ST_IDLE || !rxLine_q) begin
					quietCnt_q <= 8'd0;
				end else if (quietCnt_q != QUIET_RT) begin
					quietCnt_q <= quietCnt_q + 8'd1;
				end
				if (quietDet) begin
					progress_q <= 1'b0;
				end
				if (rxState_q == ST_IDLE) begin
					if (!rxLine_q) begin
						progress_q <= 1'b1;
						rtCnt_q    <= 4'd1;
						bitCnt_q   <= 4'd0;
						noiseAcc_q <= 1'b0;
						rxState_q  <= ST_START;
					end
				end else begin
					rtCnt_q <= rtCnt_q + 4'd1;
					if (rtCnt_q == 4'd7) begin
						smp_q[0] <= rxLine_q;
					end
					if (rtCnt_q == 4'd8) begin
						smp_q[1] <= rxLine_q;
					end
					if (midBit) begin
						noiseAcc_q <= noiseAcc_q | noisy;
						case (rxState_q)
							ST_START: begin
								if (bitVal) begin
									progress_q <= 1'b0;
									rxState_q  <= ST_IDLE;
								end
							end
							ST_DATA: begin
								shift_q  <= {bitVal, shift_q[8:1]};
								bitCnt_q <= bitCnt_q + 4'd1;
							end
							ST_STOP: begin
								charDone_q <= 1'b1;
								rxState_q <= ST_IDLE;
							end
							default: begin
								rxState_q <= ST_IDLE;
							end
						endcase
					end
					if (rtCnt_q == 4'd15) begin
						if (rxState_q == ST_START) begin
							rxState_q <= ST_DATA;
						end else if (rxState_q == ST_DATA && bitCnt_q == bitsNeed) begin
							rxState_q <= ST_STOP;
						end
					end
				end
			end
		end
	end

	// Stop sample kept with the completed character
	reg stopVal_q;
	reg noiseHit_q;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			stopVal_q  <= 1'b1;
			noiseHit_q <= 1'b0;
		end else if (midBit && rxState_q == ST_STOP) begin
			stopVal_q  <= bitVal;
			noiseHit_q <= noiseAcc_q | noisy;
		end
	end

	wire [7:0] rxByte  = nine ? shift_q[7:0] : shift_q[8:1];
	wire       rxNinth = shift_q[8];
	wire       parXor  = nine ? ^shift_q : ^shift_q[8:1];
	wire       isBreak = (shift_q == 9'h000 || (!nine && shift_q[8:1] == 8'h00)) && !stopVal_q;

	// AHB-Lite front end
	reg       wrPend_q;
	reg [7:0] wrAddr_q;

	wire accept = hsel && hready && htrans[1];
	wire rdAcc  = accept && !hwrite;
	wire rdS1   = rdAcc && hit(haddr, `SCIRX_STAT1_OFS);
	wire rdS2   = rdAcc && hit(haddr, `SCIRX_STAT2_OFS);
	wire rdData = rdAcc && hit(haddr, `SCIRX_DATA_OFS);

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	// Flags
	reg [5:0] flags1_q;
	reg       break_q;
	reg [5:0] arm1_q;
	reg       armBrk_q;
	reg       quietArm_q;
	reg       breakArm_q;
	reg [7:0] dataBuf_q;
	reg       ninth_q;

	wire [5:0] clr1   = rdData ? arm1_q : 6'h00;
	wire       clrBrk = rdData && armBrk_q;
	wire       fullNow = flags1_q[`SCIRX_S1_FULL] && !clr1[`SCIRX_S1_FULL];
	wire       loadChar = charDone_q && !fullNow;
	wire       brkHit  = loadChar && isBreak && breakArm_q;
	reg  [5:0] set1;

	always @* begin
		set1 = 6'h00;
		set1[`SCIRX_S1_OVERRUN] = charDone_q && fullNow;
		set1[`SCIRX_S1_FULL]    = loadChar;
		set1[`SCIRX_S1_NOISE]   = loadChar && noiseHit_q;
		set1[`SCIRX_S1_FRAMING] = loadChar && !stopVal_q;
		set1[`SCIRX_S1_PARITY]  = loadChar && parEn && (parXor ^ parOdd);
		set1[`SCIRX_S1_QUIET]   = quietDet && quietArm_q && rxEn;
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			flags1_q   <= 6'h00;
			break_q    <= 1'b0;
			arm1_q     <= 6'h00;
			armBrk_q   <= 1'b0;
			quietArm_q <= 1'b0;
			breakArm_q <= 1'b1;
		end else begin
			flags1_q <= (flags1_q & ~clr1) | set1;
			break_q  <= (break_q & ~clrBrk) | brkHit;
			if (rdS1) begin
				arm1_q <= flags1_q;
			end else if (rdData) begin
				arm1_q <= 6'h00;
			end
			if (rdS2) begin
				armBrk_q <= break_q;
			end else if (rdData) begin
				armBrk_q <= 1'b0;
			end
			if (!rxEn || set1[`SCIRX_S1_QUIET]) begin
				quietArm_q <= 1'b0;
			end else if (loadChar) begin
				quietArm_q <= 1'b1;
			end
			if (brkHit) begin
				breakArm_q <= 1'b0;
			end else if (rxLine_q) begin
				breakArm_q <= 1'b1;
			end
		end
	end

	// Receive buffer keeps its contents through reset
	always @(posedge core_clk) begin
		if (loadChar) begin
			dataBuf_q <= rxByte;
			ninth_q   <= brkHit ? 1'b0 : rxNinth;
		end
	end

	// Register writes in the data phase
	wire wrEn = wrPend_q && hready;

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			wrPend_q <= 1'b0;
			wrAddr_q <= 8'h00;
			baud_q   <= `SCIRX_BAUD_RST;
			ctl2_q   <= `SCIRX_CTL_RST;
			ctl3_q   <= 4'h0;
			txLoad   <= 1'b0;
		end else begin
			txLoad <= 1'b0;
			if (hready) begin
				wrPend_q <= accept && hwrite;
				wrAddr_q <= haddr;
			end
			if (wrEn) begin
				if (hit(wrAddr_q, `SCIRX_BAUD_OFS)) begin
					baud_q <= hwdata[7:0] & 8'h37;
				end
				if (hit(wrAddr_q, `SCIRX_CTL2_OFS)) begin
					ctl2_q <= hwdata[7:0] & 8'hF4;
				end
				if (hit(wrAddr_q, `SCIRX_CTL3_OFS)) begin
					ctl3_q <= hwdata[3:0];
				end
				if (hit(wrAddr_q, `SCIRX_DATA_OFS)) begin
					txLoad <= 1'b1;
				end
			end
		end
	end

	// Transmit byte, untouched by reset
	always @(posedge core_clk) begin
		if (wrEn && hit(wrAddr_q, `SCIRX_DATA_OFS)) begin
			txData <= hwdata[7:0];
		end
	end

	// Read data captured at the address phase
	reg [7:0] rdMux;

	always @* begin
		rdMux = 8'h00;
		if (hit(haddr, `SCIRX_STAT1_OFS)) begin
			rdMux = {2'b00, flags1_q};
		end else if (hit(haddr, `SCIRX_STAT2_OFS)) begin
			rdMux = {6'h00, break_q, progress_q};
		end else if (hit(haddr, `SCIRX_BAUD_OFS)) begin
			rdMux = baud_q;
		end else if (hit(haddr, `SCIRX_CTL2_OFS)) begin
			rdMux = ctl2_q;
		end else if (hit(haddr, `SCIRX_CTL3_OFS)) begin
			rdMux = {ninth_q, 3'b000, ctl3_q};
		end else if (hit(haddr, `SCIRX_DATA_OFS)) begin
			rdMux = dataBuf_q;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
		end else if (rdAcc) begin
			hrdata <= {24'h00_0000, rdMux};
		end
	end

	// Interrupt requests; break and progress never take part
	assign rxIrq = flags1_q[`SCIRX_S1_QUIET] & ctl2_q[`SCIRX_C2_QUIETIE];

	assign errIrq = (flags1_q[`SCIRX_S1_OVERRUN] & ctl3_q[`SCIRX_C3_OVRIE])
		| (flags1_q[`SCIRX_S1_NOISE] & ctl3_q[`SCIRX_C3_NOISEIE])
		| (flags1_q[`SCIRX_S1_FRAMING] & ctl3_q[`SCIRX_C3_FRAMIE])
		| (flags1_q[`SCIRX_S1_PARITY] & ctl3_q[`SCIRX_C3_PARIE]);

endmodule // scirx_status_baud

`default_nettype wire

// >>> verilog/scirx_map.vh
// Register map, field positions and timing constants of the receive block
`ifndef SCIRX_MAP_VH
`define SCIRX_MAP_VH

// Byte addresses
`define SCIRX_STAT1_OFS   8'h00
`define SCIRX_STAT2_OFS   8'h04
`define SCIRX_BAUD_OFS    8'h08
`define SCIRX_CTL2_OFS    8'h0C
`define SCIRX_CTL3_OFS    8'h10
`define SCIRX_DATA_OFS    8'h18

// status_one fields
`define SCIRX_S1_PARITY   0
`define SCIRX_S1_FRAMING  1
`define SCIRX_S1_NOISE    2
`define SCIRX_S1_OVERRUN  3
`define SCIRX_S1_QUIET    4
`define SCIRX_S1_FULL     5

// status_two fields
`define SCIRX_S2_PROGRESS 0
`define SCIRX_S2_BREAK    1

// control_two fields
`define SCIRX_C2_RXEN     2
`define SCIRX_C2_QUIETIE  4
`define SCIRX_C2_PARODD   5
`define SCIRX_C2_PAREN    6
`define SCIRX_C2_NINE     7

// control_three fields
`define SCIRX_C3_PARIE    0
`define SCIRX_C3_FRAMIE   1
`define SCIRX_C3_NOISEIE  2
`define SCIRX_C3_OVRIE    3
`define SCIRX_C3_NINTH    7

// Reset values
`define SCIRX_CTL_RST     8'h00
`define SCIRX_BAUD_RST    8'h00

// Timing
`define SCIRX_CLK_PER_RT  4
`define SCIRX_RT_PER_BIT  16
`define SCIRX_QUIET_BITS  10

`endif

// >>> verification/scirx_checker.sv
// Assertions on bus reads, transmit load, baud tick and interrupt release
`timescale 1ns/1ps
`default_nettype none
module scirx_checker (
	// Clock and reset
	input wire logic        core_clk,
	input wire logic        rst,
	// Bus
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	// Outputs
	input wire logic [7:0]  txData,
	input wire logic        txLoad,
	input wire logic        baudTick,
	input wire logic        rxIrq,
	input wire logic        errIrq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	wire logic       acc    = hsel && hready && htrans[1];
	wire logic       rdData = acc && !hwrite && haddr == 8'h18;
	wire logic       wrData = acc && hwrite && haddr == 8'h18;
	wire logic       wrCtl2 = acc && hwrite && haddr == 8'h0C;
	wire logic       wrCtl3 = acc && hwrite && haddr == 8'h10;
	wire logic [7:0] wrByte = hwdata[7:0];

	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus response not ready and okay");
	AST_TX_LOAD: assert property (wrData |-> ##2 txLoad && txData == $past(wrByte))
		else $error("data write not loaded for transmit");
	AST_TX_CAUSE: assert property (txLoad |-> $past(wrData, 2))
		else $error("transmit load without data write");
	AST_TX_HOLD: assert property ($changed(txData) |-> txLoad)
		else $error("transmit byte changed without load");
	AST_RD_UPPER: assert property (acc && !hwrite |=> hrdata[31:8] == 24'h00_0000)
		else $error("read data upper bits not zero");
	AST_STAT2_RSVD: assert property (acc && !hwrite && haddr == 8'h04 |=> hrdata[7:2] == 6'h00)
		else $error("status two unused bits not zero");
	AST_BAUD_GAP: assert property (baudTick |=> !baudTick [*8])
		else $error("baud ticks too close");
	AST_RXIRQ_FALL: assert property ($fell(rxIrq) |-> $past(rdData) || $past(wrCtl2, 2))
		else $error("receive interrupt dropped without data read or enable write");
	AST_ERRIRQ_FALL: assert property ($fell(errIrq) |-> $past(rdData) || $past(wrCtl3, 2))
		else $error("error interrupt dropped without data read or enable write");
endmodule // scirx_checker

bind scirx_status_baud scirx_checker u_chk (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hrdata, .hreadyout, .hresp, .txData, .txLoad, .baudTick, .rxIrq, .errIrq);
`default_nettype wire

// >>> verification/scirx_line_drv.sv
// Remote serial transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none
module scirx_line_drv #(
	parameter int BIT = 64
) (
	input  wire logic clk,
	output var  logic rxd
);
	initial rxd = 1'b1;
	// Start, eight bits LSB first, stop; optional glitch over one vote sample
	task automatic send(input logic [7:0] b, input logic stopBit, input logic glitch);
		logic [9:0] f;
		f = {stopBit, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rxd <= f[i];
			repeat (32) @(posedge clk);
			if (glitch && i == 1) rxd <= ~f[i];
			repeat (4) @(posedge clk);
			rxd <= f[i];
			repeat (BIT - 36) @(posedge clk);
		end
		rxd <= 1'b1;
		@(posedge clk);
	endtask
	task automatic pulse(input int n);
		rxd <= 1'b0;
		repeat (n) @(posedge clk);
		rxd <= 1'b1;
	endtask
endmodule // scirx_line_drv
`default_nettype wire

// >>> verification/sci_rx_status_and_baud_tb.sv
// Self-checking bench of receive flags, data buffer and baud generator
`timescale 1ns/1ps
`default_nettype none
module sci_rx_status_and_baud_tb;
	logic        core_clk, rst, hsel, hwrite;
	logic [7:0]  haddr;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, rd;
	wire         hready, rxd, txLoad, baudTick, rxIrq, errIrq;
	wire  [31:0] hrdata;
	wire  [7:0]  txData;
	int          failCount = 0;
	int          nChecks = 0;
	int          cycles = 0;

	scirx_status_baud i_dut (.core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout(hready), .hresp(), .hrdata, .rxdPin(rxd), .txData, .txLoad,
		.baudTick, .rxIrq, .errIrq);
	scirx_line_drv i_line (.clk(core_clk), .rxd);

	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			failCount++;
			endOfTest;
		end
	end

	task automatic endOfTest;
		if (failCount == 0 && nChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic ok);
		nChecks++;
		if (ok !== 1'b1) begin
			failCount++;
			$display("mismatch at %0t: flag or count wrong", $time);
		end
	endtask
	// Single access; data buffer never read and written in one go
	task automatic ahb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		hsel   <= 1'b1;
		haddr  <= a;
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge core_clk); while (hready !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do @(posedge core_clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		ahb(1'b0, a, 8'h00);
		nChecks++;
		if (rd !== {24'h00_0000, e}) begin
			failCount++;
			$display("mismatch at %0t: addr %h read %h expected %h", $time, a, rd, e);
		end
	endtask
	task automatic rx(input logic [7:0] b, input logic stopBit, input logic glitch);
		i_line.send(b, stopBit, glitch);
		repeat (8) @(posedge core_clk);
	endtask
	task automatic chkBaud(input logic [7:0] v, input int per);
		int n;
		ahb(1'b1, 8'h08, v);
		rdChk(8'h08, v);
		repeat (2) do @(posedge core_clk); while (baudTick !== 1'b1);
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (baudTick !== 1'b1);
		chk(n == per);
	endtask

	task automatic tBaud;
		int pd[4] = '{1, 3, 4, 13};
		for (int i = 0; i < 6; i++) if (i != 4) rdChk(8'(i * 4), 8'h00);
		ahb(1'b0, 8'h10, 8'h00);
		chk(rd[6:0] === 7'h00);
		for (int i = 0; i < 4; i++) chkBaud({2'b00, 2'(i), 4'h0}, 64 * pd[i]);
		chkBaud(8'h01, 128);
		chkBaud(8'h07, 8192);
		ahb(1'b1, 8'h08, 8'h00);
	endtask
	task automatic tRx;
		ahb(1'b1, 8'h0C, 8'h14);
		repeat (800) @(posedge core_clk);
		rdChk(8'h00, 8'h00);
		rx(8'hA5, 1'b1, 1'b0);
		rdChk(8'h00, 8'h20);
		rdChk(8'h18, 8'hA5);
		rdChk(8'h00, 8'h00);
		repeat (520) @(posedge core_clk);
		rdChk(8'h00, 8'h00);
		repeat (100) @(posedge core_clk);
		rdChk(8'h00, 8'h10);
		chk(rxIrq === 1'b1);
		ahb(1'b1, 8'h0C, 8'h04);
		@(posedge core_clk);
		chk(rxIrq === 1'b0);
		rdChk(8'h18, 8'hA5);
		rdChk(8'h00, 8'h00);
		repeat (800) @(posedge core_clk);
		rdChk(8'h00, 8'h00);
	endtask
	task automatic tOverrun;
		ahb(1'b1, 8'h10, 8'h08);
		rx(8'h11, 1'b1, 1'b0);
		rx(8'h22, 1'b1, 1'b0);
		chk(errIrq === 1'b1);
		rdChk(8'h00, 8'h28);
		rdChk(8'h18, 8'h11);
		rdChk(8'h00, 8'h00);
		rx(8'h33, 1'b1, 1'b0);
		rdChk(8'h00, 8'h20);
		rx(8'h44, 1'b1, 1'b0);
		rdChk(8'h18, 8'h33);
		rdChk(8'h00, 8'h08);
		rdChk(8'h18, 8'h33);
		rdChk(8'h00, 8'h00);
	endtask
	task automatic tBreak;
		ahb(1'b1, 8'h10, 8'h02);
		rx(8'h00, 1'b0, 1'b0);
		chk(errIrq === 1'b1);
		rdChk(8'h10, 8'h02);
		rdChk(8'h00, 8'h22);
		rdChk(8'h18, 8'h00);
		chk(errIrq === 1'b0);
		ahb(1'b0, 8'h04, 8'h00);
		chk(rd[1] === 1'b1);
		rdChk(8'h18, 8'h00);
		ahb(1'b0, 8'h04, 8'h00);
		chk(rd[1] === 1'b0);
	endtask
	task automatic tErr;
		ahb(1'b1, 8'h0C, 8'h44);
		rx(8'h01, 1'b1, 1'b0);
		rdChk(8'h00, 8'h21);
		rdChk(8'h18, 8'h01);
		rdChk(8'h00, 8'h00);
		ahb(1'b1, 8'h0C, 8'h64);
		rx(8'h01, 1'b1, 1'b0);
		rdChk(8'h00, 8'h20);
		rdChk(8'h18, 8'h01);
		ahb(1'b1, 8'h0C, 8'h84);
		rx(8'h81, 1'b1, 1'b0);
		repeat (64) @(posedge core_clk);
		rdChk(8'h00, 8'h20);
		rdChk(8'h10, 8'h82);
		rdChk(8'h18, 8'h81);
		ahb(1'b1, 8'h0C, 8'h04);
		rx(8'h03, 1'b1, 1'b1);
		rdChk(8'h00, 8'h24);
		rdChk(8'h18, 8'h03);
		rdChk(8'h00, 8'h00);
		i_line.pulse(12);
		ahb(1'b0, 8'h04, 8'h00);
		chk(rd[0] === 1'b1);
		repeat (60) @(posedge core_clk);
		ahb(1'b0, 8'h04, 8'h00);
		chk(rd[0] === 1'b0);
	endtask
	task automatic tMidReset;
		rx(8'h5A, 1'b0, 1'b0);
		ahb(1'b1, 8'h18, 8'h3C);
		ahb(1'b1, 8'h08, 8'h35);
		chk(txData === 8'h3C);
		rst <= 1'b1;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		rdChk(8'h00, 8'h00);
		rdChk(8'h08, 8'h00);
		rdChk(8'h18, 8'h5A);
		chk(txData === 8'h3C);
	endtask

	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
		tBaud;
		tRx;
		tOverrun;
		tBreak;
		tErr;
		tMidReset;
		endOfTest;
	end
endmodule // sci_rx_status_and_baud_tb
`default_nettype wire
